// file: inc/drte_pkg.sv
// Constants shared by the request and transfer-end channel logic
package drte_pkg;
  // Register byte offsets
  localparam logic [7:0] DRTE_OFS_MODE = 8'h00;
  localparam logic [7:0] DRTE_OFS_ADDR = 8'h04;
  localparam logic [7:0] DRTE_OFS_CNT = 8'h08;
  localparam logic [7:0] DRTE_OFS_SIZE = 8'h0c;
  localparam logic [7:0] DRTE_OFS_STAT = 8'h10;
  // Mode register fields
  localparam int DRTE_B_EN = 0;
  localparam int DRTE_B_ACT = 1;
  localparam int DRTE_B_NRD = 2;
  localparam int DRTE_B_EDGE = 3;
  localparam int DRTE_B_XM = 4;
  localparam int DRTE_B_CEF = 6;
  localparam int DRTE_B_CEIE = 7;
  localparam int DRTE_B_SEIE = 8;
  localparam int DRTE_B_EEF = 9;
  localparam int DRTE_B_EEIE = 10;
  localparam int DRTE_B_ERR = 11;
  localparam int DRTE_B_SGL = 12;
  localparam int DRTE_B_SZ = 13;
  // Address mode control fields
  localparam int DRTE_B_RPIE = 0;
  localparam int DRTE_B_SOIE = 1;
  localparam int DRTE_B_DOIE = 2;
  localparam int DRTE_B_XRE = 3;
  localparam logic [3:0] DRTE_ADDR_RST = 4'h0;
  // Transfer modes
  localparam logic [1:0] DRTE_XM_NORMAL = 2'h0;
  localparam logic [1:0] DRTE_XM_REPEAT = 2'h1;
  localparam logic [1:0] DRTE_XM_BLOCK = 2'h2;
  // Access sizes
  localparam logic [1:0] DRTE_SZ_BYTE = 2'h0;
  localparam logic [1:0] DRTE_SZ_WORD = 2'h1;
  localparam logic [1:0] DRTE_SZ_LONG = 2'h2;
  // Default block or repeat size in units
  localparam logic [7:0] DRTE_GRP_RST = 8'h01;
  // Channel states
  typedef enum logic [1:0] {
    DRTE_IDLE = 2'b00,
    DRTE_WAIT = 2'b01,
    DRTE_BUSY = 2'b10,
    DRTE_GAP = 2'b11
  } drte_state_e;
endpackage : drte_pkg

// file: core/drte_core.sv
// Request acceptance and transfer-end logic of one DMA channel
`timescale 1ns/100ps
module drte_core
  import drte_pkg::*;
#(
  parameter int CW = 16,
  parameter int AW = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic hw_standby,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ext_transfer_request_n,
  input wire logic unit_done,
  input wire logic src_overflow,
  input wire logic dst_overflow,
  input wire logic nmi_req,
  input wire logic addr_error,
  output logic unit_start,
  output logic [2:0] unit_bytes,
  output logic channel_active,
  output logic count_end_interrupt,
  output logic escape_end_interrupt
);

  ////////////////////////////////////////////////////////////////
  // Declarations

  logic init; // Reset or standby
  drte_state_e state_reg; // Channel sequence
  logic sync1_reg; // Pin stage one
  logic sync2_reg; // Pin stage two
  logic armed_reg; // High level seen
  logic req_reg; // Held request
  logic channel_enable_reg;
  logic nrd_reg; // Request delay select
  logic edge_reg; // 1 = falling edge mode
  logic [1:0] xmode_reg; // Transfer mode
  logic single_reg; // Single address mode
  logic [1:0] size_reg; // Access size
  logic count_end_flag_reg;
  logic count_end_irq_enable_reg;
  logic size_error_irq_enable_reg;
  logic escape_end_flag_reg;
  logic escape_end_irq_enable_reg;
  logic global_error_flag_reg;
  logic [3:0] amc_reg; // Address mode control
  logic [CW-1:0] transfer_counter_reg;
  logic [7:0] grp_size_reg; // Block or repeat size
  logic [7:0] grp_idx_reg; // Units done in group
  logic grp_done_reg; // A whole group completed
  logic ovf_pend_reg; // Overflow awaiting end
  logic force_reg; // Forced stop pending
  logic [2:0] bytes_reg; // Current unit width
  logic start_reg;
  logic active_reg;
  logic ce_irq_reg;
  logic ee_irq_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic [31:0] prdata_reg;
  // Decoded bus strobes
  logic acc; // Access phase completing
  logic wr_mode;
  logic wr_addr;
  logic wr_cnt;
  logic wr_size;
  // Sequencing terms
  logic accept; // Take held request
  logic blk; // Block mode
  logic [CW-1:0] unit_sz; // Access size in bytes
  logic [CW-1:0] need; // Bytes a request needs
  logic [CW-1:0] cnt_next; // Counter after unit
  logic cnt_hit; // Counter reached zero
  logic grp_left; // Units left in block
  logic size_err; // Size error on request
  logic rpt_end; // Repeat end on request
  logic hw_end; // Hardware ends transfer
  logic ce_set; // Count end event
  logic ee_set; // Escape end event
  logic err_evt; // NMI or address error

  ////////////////////////////////////////////////////////////////
  // Helpers

  // Access size code to byte count
  function automatic logic [2:0] sz_bytes(input logic [1:0] s);
    case (s)
      DRTE_SZ_WORD: sz_bytes = 3'h2;
      DRTE_SZ_LONG: sz_bytes = 3'h4;
      default: sz_bytes = 3'h1;
    endcase
  endfunction : sz_bytes

  // Byte address match
  function automatic logic hit(input logic [AW-1:0] a, input logic [7:0] o);
    hit = (a == AW'(o));
  endfunction : hit

  ////////////////////////////////////////////////////////////////
  // Combinational terms

  // Standby acts as a second reset source
  assign init = rst | hw_standby;
  assign acc = psel & penable & pready_reg;
  assign wr_mode = acc & pwrite & hit(paddr, DRTE_OFS_MODE);
  assign wr_addr = acc & pwrite & hit(paddr, DRTE_OFS_ADDR);
  assign wr_cnt = acc & pwrite & hit(paddr, DRTE_OFS_CNT);
  assign wr_size = acc & pwrite & hit(paddr, DRTE_OFS_SIZE);
  assign err_evt = nmi_req | addr_error;
  assign blk = (xmode_reg == DRTE_XM_BLOCK);
  assign unit_sz = CW'(sz_bytes(size_reg));
  // Block requests need a whole block of bytes
  assign need = blk ? CW'(unit_sz * CW'(grp_size_reg)) : unit_sz;
  // Zero counter is never short of bytes
  assign size_err = size_error_irq_enable_reg & (transfer_counter_reg != '0)
                    & (transfer_counter_reg < need);
  assign rpt_end = grp_done_reg & amc_reg[DRTE_B_RPIE];
  assign accept = (state_reg == DRTE_WAIT) & req_reg & channel_enable_reg
                  & ~force_reg;
  assign cnt_next = transfer_counter_reg - CW'(bytes_reg);
  // Only a move from non-zero to zero ends the transfer
  assign cnt_hit = (transfer_counter_reg != '0) & (cnt_next == '0);
  assign grp_left = blk & (grp_idx_reg + 8'h01 < grp_size_reg);

  // Conditions that end the channel by hardware
  always_comb begin
    hw_end = 1'b0;
    ce_set = 1'b0;
    ee_set = 1'b0;
    if (accept && (size_err || rpt_end)) begin
      hw_end = 1'b1;
      ee_set = 1'b1;
    end else if (state_reg == DRTE_BUSY && unit_done) begin
      if (cnt_hit) begin
        hw_end = 1'b1;
        ce_set = 1'b1;
      end else if (force_reg) begin
        hw_end = 1'b1;
      end else if (ovf_pend_reg && !grp_left) begin
        hw_end = 1'b1;
        ee_set = 1'b1;
      end else if (!channel_enable_reg && !grp_left) begin
        hw_end = 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // Request pin synchroniser

  // Two stages before edge or level logic looks
  always_ff @(posedge clk) begin
    sync1_reg <= ext_transfer_request_n;
    sync2_reg <= sync1_reg;
  end

  ////////////////////////////////////////////////////////////////
  // Request detection

  // Edge mode: rearm on a seen high level, or while idle so a fresh enable takes a low level
  always_ff @(posedge clk) begin
    if (init) begin
      armed_reg <= 1'b1;
    end else if (sync2_reg || state_reg == DRTE_IDLE) begin
      armed_reg <= 1'b1;
    end else if (accept) begin
      armed_reg <= 1'b0; // Activation restarts high watch
    end
  end

  // Held request, open only while waiting
  always_ff @(posedge clk) begin
    if (init) begin
      req_reg <= 1'b0;
    end else if (accept || state_reg != DRTE_WAIT || !channel_enable_reg) begin
      req_reg <= 1'b0;
    end else if (!sync2_reg && (armed_reg || !edge_reg)) begin
      req_reg <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Channel sequence

  // Idle, waiting, unit busy, delay gap
  always_ff @(posedge clk) begin
    if (init) begin
      state_reg <= DRTE_IDLE;
    end else begin
      case (state_reg)
        DRTE_IDLE: begin
          if (channel_enable_reg) begin
            state_reg <= DRTE_WAIT;
          end
        end
        DRTE_WAIT: begin
          if (!channel_enable_reg || hw_end) begin
            state_reg <= DRTE_IDLE;
          end else if (accept) begin
            state_reg <= DRTE_BUSY;
          end
        end
        DRTE_BUSY: begin
          if (hw_end) begin
            state_reg <= DRTE_IDLE;
          end else if (unit_done && !grp_left) begin
            // Extra cycle before requests reopen
            state_reg <= nrd_reg ? DRTE_GAP : DRTE_WAIT;
          end
        end
        DRTE_GAP: begin
          state_reg <= DRTE_WAIT;
        end
        default: begin
          state_reg <= DRTE_IDLE;
        end
      endcase
    end
  end

  // Unit launch and its width
  always_ff @(posedge clk) begin
    if (init) begin
      start_reg <= 1'b0;
      bytes_reg <= 3'h1;
    end else begin
      start_reg <= 1'b0;
      if ((accept && !hw_end)
          || (state_reg == DRTE_BUSY && unit_done && !hw_end && grp_left)) begin
        start_reg <= 1'b1;
        // Short residue moves as single bytes
        if (transfer_counter_reg != '0 && transfer_counter_reg < unit_sz) begin
          bytes_reg <= 3'h1;
        end else begin
          bytes_reg <= sz_bytes(size_reg);
        end
      end
    end
  end

  // Units within the current block or repeat group
  always_ff @(posedge clk) begin
    if (init) begin
      grp_idx_reg <= 8'h00;
      grp_done_reg <= 1'b0;
    end else if (hw_end) begin
      grp_idx_reg <= 8'h00;
      grp_done_reg <= 1'b0;
    end else if (state_reg == DRTE_BUSY && unit_done && xmode_reg != DRTE_XM_NORMAL) begin
      if (grp_idx_reg + 8'h01 >= grp_size_reg) begin
        grp_idx_reg <= 8'h00;
        grp_done_reg <= 1'b1;
      end else begin
        grp_idx_reg <= grp_idx_reg + 8'h01;
      end
    end else if (accept) begin
      grp_done_reg <= 1'b0;
    end
  end

  // Overflow is held until the unit or block finishes
  always_ff @(posedge clk) begin
    if (init || state_reg == DRTE_IDLE) begin
      ovf_pend_reg <= 1'b0;
    end else if (amc_reg[DRTE_B_XRE] && ((src_overflow && amc_reg[DRTE_B_SOIE])
                 || (dst_overflow && amc_reg[DRTE_B_DOIE]))) begin
      ovf_pend_reg <= 1'b1;
    end
  end

  // Forced stop lets the running unit finish
  always_ff @(posedge clk) begin
    if (init || state_reg == DRTE_IDLE) begin
      force_reg <= 1'b0;
    end else if (err_evt) begin
      force_reg <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Control register state

  // Enable: software sets, hardware and errors clear
  always_ff @(posedge clk) begin
    if (init) begin
      channel_enable_reg <= 1'b0;
    end else if (err_evt || hw_end) begin
      channel_enable_reg <= 1'b0;
    end else if (wr_mode) begin
      // A set is ignored while the error flag stands
      channel_enable_reg <= pwdata[DRTE_B_EN] & ~global_error_flag_reg;
    end
  end

  // Plain mode fields
  always_ff @(posedge clk) begin
    if (init) begin
      nrd_reg <= 1'b0;
      edge_reg <= 1'b0;
      xmode_reg <= DRTE_XM_NORMAL;
      single_reg <= 1'b0;
      size_reg <= DRTE_SZ_BYTE;
      count_end_irq_enable_reg <= 1'b0;
      size_error_irq_enable_reg <= 1'b0;
      escape_end_irq_enable_reg <= 1'b0;
    end else if (wr_mode) begin
      nrd_reg <= pwdata[DRTE_B_NRD];
      edge_reg <= pwdata[DRTE_B_EDGE];
      xmode_reg <= pwdata[DRTE_B_XM +: 2];
      single_reg <= pwdata[DRTE_B_SGL];
      size_reg <= pwdata[DRTE_B_SZ +: 2];
      count_end_irq_enable_reg <= pwdata[DRTE_B_CEIE];
      size_error_irq_enable_reg <= pwdata[DRTE_B_SEIE];
      escape_end_irq_enable_reg <= pwdata[DRTE_B_EEIE];
    end
  end

  // Flags: write 0 clears, a same-cycle set wins
  always_ff @(posedge clk) begin
    if (init) begin
      count_end_flag_reg <= 1'b0;
      escape_end_flag_reg <= 1'b0;
      global_error_flag_reg <= 1'b0;
    end else begin
      if (ce_set) begin
        count_end_flag_reg <= 1'b1;
      end else if (wr_mode && !pwdata[DRTE_B_CEF]) begin
        count_end_flag_reg <= 1'b0;
      end
      if (ee_set) begin
        escape_end_flag_reg <= 1'b1;
      end else if (wr_mode && !pwdata[DRTE_B_EEF]) begin
        escape_end_flag_reg <= 1'b0;
      end
      if (err_evt) begin
        global_error_flag_reg <= 1'b1;
      end else if (wr_mode && !pwdata[DRTE_B_ERR]) begin
        global_error_flag_reg <= 1'b0;
      end
    end
  end

  // Address mode control and group size
  always_ff @(posedge clk) begin
    if (init) begin
      amc_reg <= DRTE_ADDR_RST;
      grp_size_reg <= DRTE_GRP_RST;
    end else begin
      if (wr_addr) begin
        amc_reg <= pwdata[3:0];
      end
      if (wr_size) begin
        grp_size_reg <= pwdata[7:0];
      end
    end
  end

  // Counter: each finished unit takes its bytes
  always_ff @(posedge clk) begin
    if (init) begin
      transfer_counter_reg <= '0;
    end else if (state_reg == DRTE_BUSY && unit_done) begin
      transfer_counter_reg <= cnt_next; // Zero start wraps, no end
    end else if (wr_cnt) begin
      transfer_counter_reg <= pwdata[CW-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////
  // Outputs

  // Active follows sequence; interrupts are flag AND enable
  always_ff @(posedge clk) begin
    if (init) begin
      active_reg <= 1'b0;
      ce_irq_reg <= 1'b0;
      ee_irq_reg <= 1'b0;
    end else begin
      active_reg <= (state_reg == DRTE_BUSY) && !hw_end;
      ce_irq_reg <= count_end_flag_reg & count_end_irq_enable_reg;
      ee_irq_reg <= escape_end_flag_reg & escape_end_irq_enable_reg;
    end
  end

  ////////////////////////////////////////////////////////////////
  // APB slave

  // One wait state per access keeps read data registered
  always_ff @(posedge clk) begin
    if (init) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h0;
    end else begin
      pready_reg <= psel & penable & ~pready_reg;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h0;
      if (psel && penable && !pready_reg) begin
        case (paddr)
          AW'(DRTE_OFS_MODE): begin
            prdata_reg[DRTE_B_EN] <= channel_enable_reg;
            prdata_reg[DRTE_B_ACT] <= active_reg;
            prdata_reg[DRTE_B_NRD] <= nrd_reg;
            prdata_reg[DRTE_B_EDGE] <= edge_reg;
            prdata_reg[DRTE_B_XM +: 2] <= xmode_reg;
            prdata_reg[DRTE_B_CEF] <= count_end_flag_reg;
            prdata_reg[DRTE_B_CEIE] <= count_end_irq_enable_reg;
            prdata_reg[DRTE_B_SEIE] <= size_error_irq_enable_reg;
            prdata_reg[DRTE_B_EEF] <= escape_end_flag_reg;
            prdata_reg[DRTE_B_EEIE] <= escape_end_irq_enable_reg;
            prdata_reg[DRTE_B_ERR] <= global_error_flag_reg;
            prdata_reg[DRTE_B_SGL] <= single_reg;
            prdata_reg[DRTE_B_SZ +: 2] <= size_reg;
          end
          AW'(DRTE_OFS_ADDR): prdata_reg[3:0] <= amc_reg;
          AW'(DRTE_OFS_CNT): prdata_reg[CW-1:0] <= transfer_counter_reg;
          AW'(DRTE_OFS_SIZE): prdata_reg[7:0] <= grp_size_reg;
          AW'(DRTE_OFS_STAT): begin
            prdata_reg[1:0] <= state_reg;
            prdata_reg[2] <= req_reg;
            prdata_reg[3] <= ovf_pend_reg;
            prdata_reg[4] <= force_reg;
            prdata_reg[5] <= grp_done_reg;
          end
          default: pslverr_reg <= 1'b1; // Unmapped address
        endcase
      end
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign unit_start = start_reg;
  assign unit_bytes = bytes_reg;
  assign channel_active = active_reg;
  assign count_end_interrupt = ce_irq_reg;
  assign escape_end_interrupt = ee_irq_reg;

endmodule : drte_core

// file: sim/drte_checker.sv
// Port-level assertions for the channel request and transfer-end logic
`timescale 1ns/100ps
module drte_checker
  import drte_pkg::*;
#(
  parameter int CW = 16,
  parameter int AW = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic hw_standby,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic ext_transfer_request_n,
  input wire logic unit_done,
  input wire logic src_overflow,
  input wire logic dst_overflow,
  input wire logic nmi_req,
  input wire logic addr_error,
  input wire logic unit_start,
  input wire logic [2:0] unit_bytes,
  input wire logic channel_active,
  input wire logic count_end_interrupt,
  input wire logic escape_end_interrupt
);
  // One clock domain, so clock and reset are given once
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////////
  // A started unit opens the active window on the next cycle
  sequence s_open;
    unit_start ##1 channel_active;
  endsequence
  // No unit may start for a while once a forced stop lands
  sequence s_quiet;
    (!unit_start) [*8];
  endsequence
  // Fresh starts need the pin low; block follow-ons come from unit_done
  property p_start_pin;
    unit_start && !$past(unit_done) && !$past(unit_done, 2) |-> !$past(ext_transfer_request_n, 4);
  endproperty
  a_start_pin: assert property (p_start_pin) else $error("unit without request");
  property p_start_act;
    unit_start |-> s_open;
  endproperty
  a_start_act: assert property (p_start_act) else $error("unit not active");
  property p_once;
    unit_start |=> !unit_start;
  endproperty
  a_once: assert property (p_once) else $error("unit start too long");
  property p_bytes;
    unit_start |-> unit_bytes inside {3'h1, 3'h2, 3'h4};
  endproperty
  a_bytes: assert property (p_bytes) else $error("bad unit size");
  // Flag lands at the done edge, the output one cycle after
  property p_ce;
    $rose(count_end_interrupt) |-> $past(unit_done, 2);
  endproperty
  a_ce: assert property (p_ce) else $error("count end without unit");
  property p_nmi;
    nmi_req |-> ##2 s_quiet;
  endproperty
  a_nmi: assert property (p_nmi) else $error("unit after nmi");
  property p_aerr;
    addr_error |-> ##2 s_quiet;
  endproperty
  a_aerr: assert property (p_aerr) else $error("unit after address error");
  property p_stby;
    hw_standby |=> !unit_start && !channel_active && !count_end_interrupt
      && !escape_end_interrupt && unit_bytes == 3'h1;
  endproperty
  a_stby: assert property (p_stby) else $error("standby left state");
endmodule : drte_checker

bind drte_core drte_checker #(.CW(CW), .AW(AW)) u_chk (.clk(clk), .rst(rst),
  .hw_standby(hw_standby), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .ext_transfer_request_n(ext_transfer_request_n), .unit_done(unit_done),
  .src_overflow(src_overflow), .dst_overflow(dst_overflow), .nmi_req(nmi_req),
  .addr_error(addr_error), .unit_start(unit_start), .unit_bytes(unit_bytes),
  .channel_active(channel_active), .count_end_interrupt(count_end_interrupt),
  .escape_end_interrupt(escape_end_interrupt));

// file: sim/drte_partner.sv
// Far-side model: requesting peripheral plus the unit bus sequencer
`timescale 1ns/100ps
module drte_partner (
  input wire logic clk,
  input wire logic rst,
  input wire logic want,
  input wire logic pulse,
  input wire logic slow,
  input wire logic unit_start,
  output logic ext_transfer_request_n,
  output logic unit_done
);
  logic [2:0] hi_cnt = 3'h0; // Cycles left with the pin let go
  logic [3:0] dly = 4'h0; // Cycles left in the running unit
  initial unit_done = 1'b0;
  // Active low, idles high like a pulled-up line
  assign ext_transfer_request_n = !(want && hi_cnt == 3'h0);
  // Pulse style lets go after each start, so each request is a fresh fall
  always @(posedge clk) begin
    if (rst) begin
      hi_cnt <= 3'h0;
    end else if (pulse && unit_start) begin
      hi_cnt <= 3'h3;
    end else if (hi_cnt != 3'h0) begin
      hi_cnt <= hi_cnt - 3'h1;
    end
  end
  // Unit takes 2 or 6 cycles; slow mode gives faults time to land
  always @(posedge clk) begin
    unit_done <= 1'b0;
    if (rst) begin
      dly <= 4'h0;
    end else if (unit_start) begin
      dly <= slow ? 4'h6 : 4'h2;
    end else if (dly != 4'h0) begin
      dly <= dly - 4'h1;
      unit_done <= (dly == 4'h1);
    end
  end
endmodule : drte_partner

// file: sim/tb_top.sv
// Self-checking bench for the DMA request and transfer-end channel
`timescale 1ns/100ps
module tb_top;
  import drte_pkg::*;
  // Mode register bit masks
  localparam logic [31:0] EN = 32'h1 << DRTE_B_EN, RDS = 32'h1 << DRTE_B_NRD,
    EDG = 32'h1 << DRTE_B_EDGE, CEF = 32'h1 << DRTE_B_CEF, CEIE = 32'h1 << DRTE_B_CEIE,
    SEIE = 32'h1 << DRTE_B_SEIE, EEF = 32'h1 << DRTE_B_EEF, EEIE = 32'h1 << DRTE_B_EEIE,
    WRD = {30'h0, DRTE_SZ_WORD} << DRTE_B_SZ;
  logic clk = 1'b0, rst = 1'b1, hw_standby = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, rerr;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rdat, xm;
  logic src_overflow = 1'b0, dst_overflow = 1'b0, nmi_req = 1'b0, addr_error = 1'b0;
  logic want = 1'b0, pulse = 1'b0, slow = 1'b0; // Far-side controls
  logic ext_transfer_request_n, unit_done, unit_start, channel_active;
  logic count_end_interrupt, escape_end_interrupt;
  logic [2:0] unit_bytes, last_b;
  int failures = 0, checks_done = 0, starts = 0, bsum = 0, cyc = 0, t_done = 0, gap = 0;
  int s0, b0, g0;
  initial begin
    forever #4 clk = ~clk;
  end
  drte_core u_dut (.clk(clk), .rst(rst), .hw_standby(hw_standby), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ext_transfer_request_n(ext_transfer_request_n),
    .unit_done(unit_done), .src_overflow(src_overflow), .dst_overflow(dst_overflow),
    .nmi_req(nmi_req), .addr_error(addr_error), .unit_start(unit_start),
    .unit_bytes(unit_bytes), .channel_active(channel_active),
    .count_end_interrupt(count_end_interrupt), .escape_end_interrupt(escape_end_interrupt));
  drte_partner u_far (.clk(clk), .rst(rst | hw_standby), .want(want), .pulse(pulse),
    .slow(slow), .unit_start(unit_start), .ext_transfer_request_n(ext_transfer_request_n),
    .unit_done(unit_done));
  // Unit log: count, byte sum, last size, gap from done to next start
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (unit_done === 1'b1) t_done <= cyc;
    if (unit_start === 1'b1) begin
      starts <= starts + 1;
      bsum <= bsum + unit_bytes;
      last_b <= unit_bytes;
      gap <= cyc - t_done;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // One APB transfer; holds everything until pready is sampled high
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) chk("pready", 0, 1);
  endtask : apb
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask : rd
  task tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick
  task go(input logic [31:0] m, input logic [15:0] c);
    wr(DRTE_OFS_CNT, {16'h0, c});
    wr(DRTE_OFS_MODE, m | EN);
  endtask : go
  // Poll until the channel drops its enable, then confirm it went idle
  task fin();
    int n;
    n = 0;
    do begin
      rd(DRTE_OFS_MODE);
      n++;
    end while (rdat[DRTE_B_EN] !== 1'b0 && n < 80);
    chk("en", rdat[DRTE_B_EN], 0);
    rd(DRTE_OFS_MODE);
    chk("act", rdat[DRTE_B_ACT], 0);
  endtask : fin
  ////////////////////////////////////////////////////////////////////////
  task t_regs();
    rd(DRTE_OFS_MODE);
    chk("mode", rdat, 0);
    rd(DRTE_OFS_ADDR);
    chk("addr", rdat, {28'h0, DRTE_ADDR_RST});
    rd(DRTE_OFS_SIZE);
    chk("size", rdat, {24'h0, DRTE_GRP_RST});
    rd(8'h14);
    chk("unmapped", {rerr, rdat[30:0]}, 32'h80000000);
  endtask : t_regs
  task t_count();
    s0 = starts;
    want <= 1'b1;
    go(CEIE, 16'h2);
    fin();
    chk("units", starts - s0, 2);
    chk("flags", rdat & (CEF | EEF), CEF);
    chk("ce irq", count_end_interrupt, 1);
    g0 = gap;
    wr(DRTE_OFS_MODE, 32'h0);
    tick(2);
    chk("ce clr", count_end_interrupt, 0);
    go(RDS, 16'h2);
    fin();
    chk("delay", gap - g0, 1);
    wr(DRTE_OFS_MODE, 32'h0);
  endtask : t_count
  // Residue in bytes without size error, then the size error itself
  task t_size();
    s0 = starts;
    b0 = bsum;
    go(WRD, 16'h3);
    fin();
    chk("res units", starts - s0, 2);
    chk("res bytes", bsum - b0, 3);
    chk("res last", last_b, 1);
    s0 = starts;
    go(WRD | SEIE | EEIE, 16'h3);
    fin();
    chk("se units", starts - s0, 1);
    chk("se flags", rdat & (CEF | EEF), EEF);
    chk("ee irq", escape_end_interrupt, 1);
    wr(DRTE_OFS_MODE, 32'h0);
  endtask : t_size
  task t_zero();
    slow <= 1'b1;
    go(32'h0, 16'h0);
    tick(60);
    rd(DRTE_OFS_MODE);
    chk("zero run", rdat[DRTE_B_EN], 1);
    wr(DRTE_OFS_MODE, 32'h0);
    s0 = starts;
    tick(40);
    chk("sw stop", (starts - s0) <= 1, 1);
    chk("sw idle", channel_active, 0);
  endtask : t_zero
  // Pin held low gives one unit only; fresh falls give the rest
  task t_edge();
    s0 = starts;
    slow <= 1'b0;
    go(EDG, 16'h4);
    tick(50);
    chk("edge one", starts - s0, 1);
    want <= 1'b0;
    pulse <= 1'b1;
    tick(3);
    want <= 1'b1;
    fin();
    chk("edge all", starts - s0, 4);
    pulse <= 1'b0;
    wr(DRTE_OFS_MODE, 32'h0);
  endtask : t_edge
  task t_err();
    slow <= 1'b1;
    for (int i = 0; i < 2; i++) begin
      go(32'h0, 16'h0);
      tick(20);
      if (i == 0) nmi_req <= 1'b1;
      else addr_error <= 1'b1;
      tick(1);
      nmi_req <= 1'b0;
      addr_error <= 1'b0;
      fin();
      chk("err", rdat[DRTE_B_ERR], 1);
      wr(DRTE_OFS_MODE, (32'h1 << DRTE_B_ERR) | EN);
      rd(DRTE_OFS_MODE);
      chk("err lock", rdat[DRTE_B_EN], 0);
      wr(DRTE_OFS_MODE, 32'h0); // Error flag cleared before any restart
    end
  endtask : t_err
  // Repeat and block groups of two, stop on the next request, resume
  task t_grp();
    slow <= 1'b0;
    wr(DRTE_OFS_SIZE, 32'h2);
    wr(DRTE_OFS_ADDR, 32'h1 << DRTE_B_RPIE);
    for (int i = 0; i < 2; i++) begin
      xm = {30'h0, (i == 0) ? DRTE_XM_REPEAT : DRTE_XM_BLOCK} << DRTE_B_XM;
      s0 = starts;
      go(xm | EEIE, 16'h8);
      fin();
      chk("grp units", starts - s0, 2);
      chk("grp flag", rdat & EEF, EEF);
      wr(DRTE_OFS_MODE, xm | EEIE | EN);
      fin();
      chk("grp resume", starts - s0, 4);
      wr(DRTE_OFS_MODE, 32'h0);
    end
    wr(DRTE_OFS_SIZE, {24'h0, DRTE_GRP_RST});
  endtask : t_grp
  task t_ovf();
    slow <= 1'b1;
    wr(DRTE_OFS_ADDR, (32'h1 << DRTE_B_SOIE) | (32'h1 << DRTE_B_DOIE) | (32'h1 << DRTE_B_XRE));
    for (int i = 0; i < 2; i++) begin
      go(EEIE, 16'h0);
      tick(6);
      s0 = starts;
      if (i == 0) src_overflow <= 1'b1;
      else dst_overflow <= 1'b1;
      tick(1);
      src_overflow <= 1'b0;
      dst_overflow <= 1'b0;
      fin();
      chk("ovf flag", rdat & EEF, EEF);
      chk("ovf units", starts - s0, 0);
      wr(DRTE_OFS_MODE, 32'h0);
    end
  endtask : t_ovf
  task t_stby();
    go(CEIE, 16'h0);
    tick(8);
    hw_standby <= 1'b1;
    tick(1);
    hw_standby <= 1'b0;
    tick(1);
    chk("stby act", channel_active, 0);
    rd(DRTE_OFS_MODE);
    chk("stby mode", rdat, 0);
  endtask : t_stby
  ////////////////////////////////////////////////////////////////////////
  task summarize();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : summarize
  // Whole run is well under a thousand cycles; this cuts a hang short
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    summarize();
  end
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    want <= 1'b1;
    t_count();
    t_size();
    t_zero();
    t_edge();
    t_err();
    t_grp();
    t_ovf();
    t_stby();
    summarize();
  end
endmodule : tb_top
